// *** common/rsc_params.svh ***
// Constants for the relay switch control logic: codes, reset values, widths and timing.
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

// Frame length and channel count.
`define RSC_FRAME_BITS 16
`define RSC_NCH 8
`define RSC_GROUP_W 4

// Serial register codes, carried in the address field of a frame.
`define RSC_ADR_OUT 3'h0
`define RSC_ADR_MAP0 3'h1
`define RSC_ADR_MAP1 3'h2
`define RSC_ADR_OVL 3'h3
`define RSC_ADR_OT 3'h4
`define RSC_ADR_OSM 3'h5
`define RSC_ADR_OLC 3'h6
`define RSC_ADR_OLON 3'h7

// Reset values: input zero steers channel 2, input one steers channel 3.
`define RSC_MAP0_RST 8'h04
`define RSC_MAP1_RST 8'h08
`define RSC_OUT_RST 8'h00
`define RSC_TER_RST 1'h1

// Fixed channels used in limp home, and the channels able to work as high side.
`define RSC_LH_CH0 2
`define RSC_LH_CH1 3
`define RSC_HS_CAPABLE 8'hfc

// Restart time in limp home, in microseconds, and the clock rate in MHz.
`define RSC_RETRY_US 200
`define RSC_CLK_MHZ 10
`define RSC_RETRY_CYC (`RSC_RETRY_US * `RSC_CLK_MHZ)
`define RSC_RETRY_W 12

`endif

// *** common/rsc_pkg.sv ***
// Types shared by the relay switch control logic.
package rsc_pkg;

	// One sixteen bit serial frame; on the reply the top bit carries the error flag.
	typedef struct packed {
		logic wr;
		logic [2:0] addr;
		logic [3:0] rsvd;
		logic [7:0] data;
	} rsc_frame_s;

	// Per-channel indications from the power stage.
	typedef struct packed {
		logic [7:0] ovl;
		logic [7:0] ot;
		logic [7:0] osm;
		logic [7:0] ol_on;
		logic [7:0] hs_cfg;
	} rsc_ana_s;

	// Every level that arrives from outside the clock domain.
	typedef struct packed {
		logic cs_b;
		logic sclk;
		logic si;
		logic idle;
		logic in0;
		logic in1;
		logic vdd;
		logic limp;
		rsc_ana_s ana;
	} rsc_pins_s;

	// Serial engine states.
	typedef enum logic [0:0] {
		RSC_SPI_IDLE,
		RSC_SPI_ACTIVE
	} rsc_spi_e;

endpackage

// *** src/rsc_chan.sv ***
// One output channel: overload and thermal latches and the limp home restart timer.
`timescale 1ns/1ns
`include "rsc_params.svh"

module rsc_chan (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Requests and conditions.
	input wire logic req,
	input wire logic limp,
	input wire logic ovl_det,
	input wire logic ot_det,
	input wire logic clr_ovl,
	input wire logic clr_ot,
	// Result.
	output logic drive,
	output logic ovl_flag,
	output logic ot_flag
);

	logic ovl_q;
	logic ovl_d;
	logic ot_q;
	logic ot_d;
	logic [`RSC_RETRY_W-1:0] retry_q;
	logic [`RSC_RETRY_W-1:0] retry_d;
	logic restart;

	// Next state of the latches; a thermal detection in the clearing cycle wins, an overload one counts only while driving.
	always_comb
	begin
		drive = req & ~ovl_q & ~ot_q;
		restart = limp & ovl_q & req & (retry_q == `RSC_RETRY_W'(`RSC_RETRY_CYC - 1)); // [RULE11]
		retry_d = (limp & ovl_q & req) ? retry_q + `RSC_RETRY_W'(1) : '0; // [RULE11]
		ovl_d = ovl_q;
		if (clr_ovl || restart)
		begin
			ovl_d = 1'b0;
		end
		if (ovl_det && drive)
		begin
			ovl_d = 1'b1; // [RULE10]
		end
		ot_d = ot_q;
		if (clr_ot)
		begin
			ot_d = 1'b0;
		end
		if (ot_det)
		begin
			ot_d = 1'b1; // [RULE12]
		end
		ovl_flag = ovl_q;
		ot_flag = ot_q;
	end

	// Latch registers.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ovl_q <= 1'b0;
			ot_q <= 1'b0;
			retry_q <= '0;
		end
		else
		begin
			ovl_q <= ovl_d;
			ot_q <= ot_d;
			retry_q <= retry_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_ovl_latch: assert property ((ovl_det && drive) |=> (ovl_q && !drive)) // [RULE10]
		else $error("Overload did not latch the channel off.");
	a_ovl_hold: assert property ((ovl_q && !clr_ovl && !limp) |=> ovl_q) // [RULE10]
		else $error("Overload latch released without a clear.");
	a_ot_hold: assert property ((ot_q && !clr_ot) |=> (ot_q && !drive)) // [RULE12]
		else $error("Thermal latch released without a clear.");
	a_retry_restart: assert property ((ovl_q && limp && req && !ovl_det && retry_q == `RSC_RETRY_W'(`RSC_RETRY_CYC - 1))
		|=> !ovl_q) // [RULE11]
		else $error("Limp home restart did not happen at the restart time.");

endmodule

// *** src/rsc_top.sv ***
// Relay switch control logic: serial slave, input mapping, limp home and diagnosis latches.
// Overview of operation
// [RULE1] Every control and diagnosis exchange is a sixteen bit serial frame.
// [RULE2] Shift register passes data through, so chains with eight bit devices work; the code acts only on whole sixteen bit groups.
// [RULE3] The host keeps the serial clock at or below five megahertz.
// [RULE4] Chip select is active low; an undriven pin reads deasserted.
// [RULE5] Serial output is released whenever chip select is high.
// [RULE6] Idle pin high puts the device into idle mode, all channels off.
// [RULE7] By default and in limp home, input zero drives channel 2, input one channel 3.
// [RULE8] Input to channel mapping is written serially; one input may drive many channels.
// [RULE9] Limp home routes inputs to channels 2 and 3 while idle is low.
// [RULE10] Overload switches a channel off until the host re-enables it.
// [RULE11] In limp home an overloaded channel with its input high restarts after the retry time.
// [RULE12] Each channel has over-temperature sensing whose shutdown latches the channel off.
// [RULE13] Serial access works only with digital supply present; channel states are kept.
// [RULE14] Diagnostic conditions are latched flags read over the serial link.
// [RULE15] Output status monitor bits are reported; test current enabled per channel serially.
// [RULE16] On-state open load diagnosis only for channels driving from the high side.
// [RULE17] Channels 0 and 1 are low side; others follow their detected configuration.
// [RULE18] Frames count only in whole sixteen bit groups; sample and shift on opposite edges.
`timescale 1ns/1ns
`include "rsc_params.svh"

module rsc_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Serial link pins.
	input wire logic chip_select_low,
	input wire logic sclk,
	input wire logic si,
	output logic so,
	output logic so_oe_b,
	// Control pins and supply state.
	input wire logic idle,
	input wire logic parallel_input_zero,
	input wire logic parallel_input_one,
	input wire logic vdd_present,
	input wire logic limp_home,
	// Power stage indications.
	input wire rsc_pkg::rsc_ana_s ana,
	// Power stage controls.
	output logic [7:0] channel_on,
	output logic [7:0] open_load_test_current,
	output logic idle_mode
);

	rsc_pkg::rsc_pins_s pins_raw;
	rsc_pkg::rsc_pins_s meta_q;
	rsc_pkg::rsc_pins_s pins_q;
	logic sclk_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_act;
	rsc_pkg::rsc_spi_e state_q;
	rsc_pkg::rsc_spi_e state_d;
	logic [15:0] sh_q;
	logic [15:0] sh_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic any_q;
	logic any_d;
	logic so_q;
	logic so_d;
	logic so_oe_b_q;
	logic ter_q;
	logic ter_d;
	logic [2:0] sel_q;
	logic [2:0] sel_d;
	logic [7:0] out_ctl_q;
	logic [7:0] out_ctl_d;
	logic [7:0] map0_q;
	logic [7:0] map0_d;
	logic [7:0] map1_q;
	logic [7:0] map1_d;
	logic [7:0] olc_q;
	logic [7:0] olc_d;
	logic [7:0] olon_q;
	logic [7:0] olon_d;
	logic [7:0] clr_ovl;
	logic [7:0] clr_ot;
	logic [7:0] rd_data;
	logic frame_end;
	rsc_pkg::rsc_frame_s frame;
	rsc_pkg::rsc_frame_s resp;
	logic [7:0] req;
	logic [7:0] drive;
	logic [7:0] ovl_flag;
	logic [7:0] ot_flag;
	logic [7:0] hs_eff;
	logic [7:0] ch_on_q;
	logic idle_q;

	// Two flip-flops for every outside level; the first stage is read only by the second.
	assign pins_raw = '{cs_b: chip_select_low, sclk: sclk, si: si, idle: idle, in0: parallel_input_zero,
		in1: parallel_input_one, vdd: vdd_present, limp: limp_home, ana: ana};

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= '{cs_b: 1'b1, default: '0}; // [RULE4]
			pins_q <= '{cs_b: 1'b1, default: '0};
			sclk_prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= pins_raw;
			pins_q <= meta_q;
			sclk_prev_q <= pins_q.sclk;
		end
	end

	// Edge finding on the synchronised serial clock, and the select window.
	always_comb
	begin
		sclk_rise = pins_q.sclk & ~sclk_prev_q;
		sclk_fall = ~pins_q.sclk & sclk_prev_q;
		cs_act = ~pins_q.cs_b & pins_q.vdd; // [RULE4] [RULE13]
		frame = rsc_pkg::rsc_frame_s'(sh_q);
		frame_end = (state_q == rsc_pkg::RSC_SPI_ACTIVE) && !cs_act;
		hs_eff = pins_q.ana.hs_cfg & `RSC_HS_CAPABLE; // [RULE17]
	end

	// Reply contents picked by the address of the last accepted frame.
	always_comb
	begin
		case (sel_q)
			`RSC_ADR_OUT: rd_data = out_ctl_q;
			`RSC_ADR_MAP0: rd_data = map0_q;
			`RSC_ADR_MAP1: rd_data = map1_q;
			`RSC_ADR_OVL: rd_data = ovl_flag; // [RULE14]
			`RSC_ADR_OT: rd_data = ot_flag; // [RULE14]
			`RSC_ADR_OSM: rd_data = pins_q.ana.osm; // [RULE15]
			`RSC_ADR_OLC: rd_data = olc_q;
			`RSC_ADR_OLON: rd_data = olon_q;
			default: rd_data = '0;
		endcase
		resp = '{wr: ter_q, addr: sel_q, rsvd: '0, data: rd_data};
	end

	// Serial engine: sample on falling edges, shift out on rising edges, act at deselect.
	always_comb
	begin
		state_d = state_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		any_d = any_q;
		so_d = so_q;
		ter_d = ter_q;
		sel_d = sel_q;
		out_ctl_d = out_ctl_q;
		map0_d = map0_q;
		map1_d = map1_q;
		olc_d = olc_q;
		clr_ovl = '0;
		clr_ot = '0;
		olon_d = olon_q;
		case (state_q)
			rsc_pkg::RSC_SPI_IDLE:
			begin
				if (cs_act)
				begin
					state_d = rsc_pkg::RSC_SPI_ACTIVE;
					sh_d = resp;
					cnt_d = '0;
					any_d = 1'b0;
				end
			end
			rsc_pkg::RSC_SPI_ACTIVE:
			begin
				if (!cs_act)
				begin
					state_d = rsc_pkg::RSC_SPI_IDLE;
					// Only whole groups with the supply still present count; the last sixteen bits are the frame.
					if (any_q && cnt_q == '0 && pins_q.vdd) // [RULE18] [RULE1] [RULE2] [RULE13]
					begin
						ter_d = 1'b0;
						sel_d = frame.addr;
						if (frame.wr)
						begin
							case (frame.addr)
								`RSC_ADR_OUT: out_ctl_d = frame.data;
								`RSC_ADR_MAP0: map0_d = frame.data; // [RULE8]
								`RSC_ADR_MAP1: map1_d = frame.data; // [RULE8]
								`RSC_ADR_OVL: clr_ovl = frame.data; // [RULE10]
								`RSC_ADR_OT: clr_ot = frame.data;
								`RSC_ADR_OLC: olc_d = frame.data; // [RULE15]
								`RSC_ADR_OLON: olon_d = olon_q & ~frame.data;
								default: sel_d = frame.addr;
							endcase
						end
					end
					else
					begin
						ter_d = 1'b1; // [RULE18]
					end
				end
				else
				begin
					if (sclk_rise)
					begin
						so_d = sh_q[15]; // [RULE2]
					end
					if (sclk_fall)
					begin
						sh_d = {sh_q[14:0], pins_q.si}; // [RULE18]
						cnt_d = cnt_q + 4'h1;
						any_d = 1'b1;
					end
				end
			end
			default: state_d = rsc_pkg::RSC_SPI_IDLE;
		endcase
		// On-state open load is latched only for high side channels that are on; set wins.
		olon_d = olon_d | (pins_q.ana.ol_on & hs_eff & ch_on_q); // [RULE16] [RULE14]
	end

	// Channel requests from serial control, mapped inputs or the limp home routing.
	always_comb
	begin
		req = '0;
		if (pins_q.limp)
		begin
			req[`RSC_LH_CH0] = pins_q.in0; // [RULE9] [RULE7]
			req[`RSC_LH_CH1] = pins_q.in1; // [RULE9] [RULE7]
		end
		else
		begin
			req = out_ctl_q | (map0_q & {8{pins_q.in0}}) | (map1_q & {8{pins_q.in1}}); // [RULE8]
		end
	end

	// One protection cell per channel.
	for (genvar i = 0; i < `RSC_NCH; i++)
	begin : g_ch
		rsc_chan u_chan (
			.clk(clk),
			.rst_b(rst_b),
			.req(req[i]),
			.limp(pins_q.limp),
			.ovl_det(pins_q.ana.ovl[i]),
			.ot_det(pins_q.ana.ot[i]),
			.clr_ovl(clr_ovl[i]),
			.clr_ot(clr_ot[i]),
			.drive(drive[i]),
			.ovl_flag(ovl_flag[i]),
			.ot_flag(ot_flag[i])
		);
	end

	// Registers; the serial engine only leaves idle with the digital supply present.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_q <= rsc_pkg::RSC_SPI_IDLE;
			sh_q <= '0;
			cnt_q <= '0;
			any_q <= 1'b0;
			so_q <= 1'b0;
			so_oe_b_q <= 1'b1;
			ter_q <= `RSC_TER_RST;
			sel_q <= `RSC_ADR_OUT;
			out_ctl_q <= `RSC_OUT_RST;
			map0_q <= `RSC_MAP0_RST; // [RULE7]
			map1_q <= `RSC_MAP1_RST; // [RULE7]
			olc_q <= '0;
			olon_q <= '0;
			ch_on_q <= '0;
			idle_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			any_q <= any_d;
			so_q <= so_d;
			so_oe_b_q <= ~cs_act; // [RULE5]
			ter_q <= ter_d;
			sel_q <= sel_d;
			out_ctl_q <= out_ctl_d;
			map0_q <= map0_d;
			map1_q <= map1_d;
			olc_q <= olc_d;
			olon_q <= olon_d;
			ch_on_q <= drive & ~{8{pins_q.idle}}; // [RULE6]
			idle_q <= pins_q.idle; // [RULE6]
		end
	end

	assign so = so_q;
	assign so_oe_b = so_oe_b_q;
	assign channel_on = ch_on_q;
	assign open_load_test_current = olc_q;
	assign idle_mode = idle_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_frame_good;
		frame_end && any_q && cnt_q == 4'h0 && pins_q.vdd;
	endsequence
	sequence s_frame_bad;
		frame_end && !(any_q && cnt_q == 4'h0 && pins_q.vdd);
	endsequence

	a_frame_bad: assert property (s_frame_bad |=> ter_q && resp.wr) // [RULE18]
		else $error("Incomplete frame did not raise the error flag.");
	a_frame_good: assert property (s_frame_good |=> !ter_q) // [RULE1]
		else $error("Whole frame did not clear the error flag.");
	a_so_tristate: assert property (pins_q.cs_b |=> so_oe_b) // [RULE5]
		else $error("Serial output driven while deselected.");
	a_daisy_delay: assert property ((state_q == rsc_pkg::RSC_SPI_ACTIVE && cs_act && sclk_rise)
		|=> so == $past(sh_q[15])) // [RULE2]
		else $error("Serial output is not the shift register top bit.");
	a_limp_route: assert property ((pins_q.limp && !pins_q.idle && pins_q.in0 && !ot_flag[2] && !ovl_flag[2])
		|=> channel_on[2]) // [RULE9]
		else $error("Limp home input zero did not drive channel 2.");
	a_idle_off: assert property (pins_q.idle |=> channel_on == 8'h00 && idle_mode) // [RULE6]
		else $error("Channels on during idle mode.");
	a_spi_gated: assert property (!pins_q.vdd |=> $stable(out_ctl_q) && $stable(map0_q)) // [RULE13]
		else $error("Serial write without digital supply.");
	a_olon_hs_only: assert property ((olon_q & ~`RSC_HS_CAPABLE) == 8'h00) // [RULE16]
		else $error("On-state open load flagged on a low side channel.");
	a_map_route: assert property ((!pins_q.limp && pins_q.in1) |-> (req & map1_q) == map1_q) // [RULE8]
		else $error("Mapped input one did not request its channels.");

endmodule

// *** test/rsc_host.sv ***
// Host model that plays serial frames into the relay switch control logic and collects the replies.
`timescale 1ns/1ns

module rsc_host (
	// Clock used only to pace the frame timing.
	input wire logic clk,
	// Serial link pins.
	output logic chip_select_low,
	output logic sclk,
	output logic si,
	input wire logic so,
	input wire logic so_oe_b
);
	// Rest levels match the pin pull-up on select and the pull-downs on clock and data.
	initial
	begin
		chip_select_low = 1'h1;
		sclk = 1'h0;
		si = 1'h0;
	end

	// Waits some clock edges, then steps just past the edge so that changes never race it.
	task automatic wait_clk(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask

	// One exchange of n bits, most significant first; a released output is collected as unknown.
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = '0;
		wait_clk(1);
		chip_select_low = 1'h0;
		wait_clk(8);
		for (int i = n - 1; i >= 0; i--)
		begin
			// Data changes on the rising clock edge; the reply bit is taken as the clock falls.
			sclk = 1'h1;
			si = tx[i];
			wait_clk(4);
			sclk = 1'h0;
			rx = {rx[30:0], so_oe_b ? 1'hx : so};
			wait_clk(4);
		end
		// Select goes high after the last of the n bits; the released data line falls to its pull-down.
		chip_select_low = 1'h1;
		si = 1'h0;
		wait_clk(6);
	endtask
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the relay switch control logic.
`timescale 1ns/1ns
`include "rsc_params.svh"

module tb_top;
	// Pins and bench state.
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic idle = 1'h0;
	logic parallel_input_zero = 1'h0;
	logic parallel_input_one = 1'h0;
	logic vdd_present = 1'h1;
	logic limp_home = 1'h0;
	rsc_pkg::rsc_ana_s ana = '0;
	logic chip_select_low, sclk, si, so, so_oe_b, idle_mode;
	logic [7:0] channel_on;
	logic [7:0] open_load_test_current;
	logic [31:0] rx;
	int num_errors = 0;
	int cmp_count = 0;
	// Rows: idle, limp home, input zero, input one, then the channels and idle flag they should give.
	logic [12:0] rows [8] = '{
		{4'h0, 8'h00, 1'h0}, {4'h2, 8'h04, 1'h0}, {4'h1, 8'h08, 1'h0}, {4'h3, 8'h0c, 1'h0},
		{4'h7, 8'h0c, 1'h0}, {4'h6, 8'h04, 1'h0}, {4'hb, 8'h00, 1'h1}, {4'hf, 8'h00, 1'h1}};

	// Bench clock, 100 ns period.
	always #50 clk = ~clk;

	// Device under test and the host on its serial side.
	rsc_top i_rsc_top (.clk, .rst_b, .chip_select_low, .sclk, .si, .so, .so_oe_b, .idle,
		.parallel_input_zero, .parallel_input_one, .vdd_present, .limp_home, .ana, .channel_on,
		.open_load_test_current, .idle_mode);
	rsc_host i_rsc_host (.clk, .chip_select_low, .sclk, .si, .so, .so_oe_b);

	// Steps past k rising edges, so every drive lands the same small delay after an edge.
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask

	// Compares with case equality, so an unknown passes only where an unknown is expected.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Serial exchange through the host model.
	task automatic sx(input int n, input logic [31:0] tx);
		i_rsc_host.xfer(n, tx, rx);
	endtask

	// Register write, then time for the channel path to follow.
	task automatic wr(input logic [2:0] addr, input logic [7:0] data);
		sx(16, {16'h0000, 1'h1, addr, 4'h0, data});
		step(3);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence: reset, table rows, then the serial and protection cases.
	initial
	begin
		step(6);
		chk({6'h00, so_oe_b, idle_mode, channel_on}, 16'h0200);
		chk({8'h00, open_load_test_current}, 16'h0000);
		rst_b = 1'h1;
		step(2);
		for (int r = 0; r < 8; r++)
		begin
			{idle, limp_home, parallel_input_zero, parallel_input_one} = rows[r][12:9];
			step(5);
			chk({7'h00, idle_mode, channel_on}, {7'h00, rows[r][0], rows[r][8:1]});
		end
		{idle, limp_home, parallel_input_one} = 3'h0;
		parallel_input_zero = 1'h1;
		// Remapping input zero onto three channels; the first reply still flags the reset.
		wr(3'h1, 8'h31);
		chk({15'h0000, rx[15]}, 16'h0001);
		chk({8'h00, channel_on}, 16'h0031);
		wr(3'h6, 8'ha5);
		chk(rx[15:0], 16'h1031);
		chk({8'h00, open_load_test_current}, 16'h00a5);
		ana.osm = 8'h5a;
		sx(16, 32'h00005000);
		chk(rx[15:0], 16'h60a5);
		// A short frame is refused; a double frame passes the first half through and acts on the second.
		sx(8, 32'h00000055);
		sx(32, 32'h12345000);
		chk(rx[31:16], 16'hd05a);
		chk(rx[15:0], 16'h1234);
		sx(16, 32'h00000000);
		chk(rx[15:0], 16'h505a);
		// Overload and thermal latches hold the channel off until cleared serially; the overload flags read back.
		ana.ovl[4] = 1'h1;
		step(4);
		ana.ovl[4] = 1'h0;
		step(4);
		chk({8'h00, channel_on}, 16'h0021);
		sx(16, 32'h00003000);
		wr(3'h3, 8'h10);
		chk(rx[15:0], 16'h3010);
		chk({8'h00, channel_on}, 16'h0031);
		ana.ot[5] = 1'h1;
		step(4);
		ana.ot[5] = 1'h0;
		step(4);
		chk({8'h00, channel_on}, 16'h0011);
		wr(3'h4, 8'h20);
		chk(rx[15:0], 16'h3000);
		chk({8'h00, channel_on}, 16'h0031);
		// On-state open load latches only on channels that are on, high side and not fixed low side.
		ana.hs_cfg = 8'hff;
		ana.ol_on = 8'h33;
		step(4);
		ana.ol_on = 8'h00;
		sx(16, 32'h00007000);
		sx(16, 32'h0000f0ff);
		chk(rx[15:0], 16'h7030);
		sx(16, 32'h00000000);
		chk(rx[15:0], 16'h7000);
		// Limp home ignores the map and restarts an overloaded channel after the retry time.
		limp_home = 1'h1;
		step(5);
		chk({8'h00, channel_on}, 16'h0004);
		ana.ovl[2] = 1'h1;
		step(4);
		ana.ovl[2] = 1'h0;
		step(`RSC_RETRY_CYC - 200);
		chk({8'h00, channel_on}, 16'h0000);
		step(300);
		chk({8'h00, channel_on}, 16'h0004);
		// Without the digital supply the link stays released and nothing is written.
		limp_home = 1'h0;
		vdd_present = 1'h0;
		step(4);
		sx(16, 32'h0000e000);
		chk(rx[15:0], 16'hxxxx);
		chk({8'h00, open_load_test_current}, 16'h00a5);
		// A second reset in mid-run brings back the default routing and the error flag.
		vdd_present = 1'h1;
		rst_b = 1'h0;
		step(2);
		chk({6'h00, so_oe_b, idle_mode, channel_on}, 16'h0200);
		chk({8'h00, open_load_test_current}, 16'h0000);
		rst_b = 1'h1;
		step(5);
		chk({8'h00, channel_on}, 16'h0004);
		sx(16, 32'h00000000);
		chk(rx[15:0], 16'h8000);
		tally_and_finish();
	end

	// Watchdog set well beyond the expected run of about 0.4 ms.
	initial
	begin
		#1000000;
		num_errors++;
		tally_and_finish();
	end
endmodule
